// file: rtl/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
  parameter int               WIDTH = 3,
  parameter logic [WIDTH-1:0] INIT  = '0
) (
  input  wire logic             sys_clk_in,
  input  wire logic             resetn_in,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_s;

  sync_s r_reg;
  sync_s r_next;

  // first stage feeds only the second stage
  always_comb begin
    r_next        = r_reg;
    r_next.first  = pin_in;
    r_next.second = r_reg.first;
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      r_reg <= {INIT, INIT};
    end else begin
      r_reg <= r_next;
    end
  end

  assign sync_out = r_reg.second;
endmodule

// file: rtl/result_fifo.sv
`timescale 1ns/1ps
module result_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 32
) (
  input  wire logic             sys_clk_in,
  input  wire logic             resetn_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  word_stream_if.src            rd_if
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr_ptr;
    logic [AW-1:0]               rd_ptr;
    logic [AW:0]                 count;
  } fifo_s;

  fifo_s r_reg;
  fifo_s r_next;
  logic  push;
  logic  pop;

  assign wr_ready_out = (r_reg.count != (AW+1)'(DEPTH));
  assign push         = wr_valid_in && wr_ready_out;
  assign pop          = rd_if.ready && (r_reg.count != '0);

  always_comb begin
    r_next = r_reg;
    if (push) begin
      r_next.mem[r_reg.wr_ptr] = wr_data_in;
      r_next.wr_ptr            = r_reg.wr_ptr + 1'b1;
    end
    if (pop) begin
      r_next.rd_ptr = r_reg.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      r_next.count = r_reg.count + 1'b1;
    end else if (pop && !push) begin
      r_next.count = r_reg.count - 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign rd_if.data  = r_reg.mem[r_reg.rd_ptr];
  assign rd_if.valid = (r_reg.count != '0);
endmodule

// file: rtl/sar_adc_serial_sequencer.sv
`timescale 1ns/1ps
`include "sar_seq_defs.svh"
module sar_adc_serial_sequencer (
  input  wire logic                sys_clk_in,
  input  wire logic                resetn_in,
  input  wire logic                cs_n_in,
  input  wire logic                sclk_in,
  input  wire logic                din_in,
  output logic                     dout_out,
  output logic                     dout_oe_out,
  input  wire logic [11:0]         conv_data_in,
  input  wire logic                conv_valid_in,
  output logic                     conv_ready_out,
  output sar_seq_pkg::chan_t       mux_sel_out,
  output logic                     hold_out,
  output logic                     range_sel_out,
  output logic                     coding_straight_out,
  output sar_seq_pkg::pmode_t      power_mode_out,
  output logic                     shutdown_out,
  output logic                     seq_active_out
);
  import sar_seq_pkg::*;

  seq_state_s  r_reg;
  seq_state_s  r_next;
  logic [2:0]  pins_s;
  logic        cs_n_s;
  logic        sclk_s;
  logic        din_s;
  logic        cs_fall;
  logic        cs_rise;
  logic        sclk_fall;
  logic        sclk_rise;
  logic        frame_done;
  logic        wr_flag;
  logic [1:0]  seq_field;
  logic        load_result;
  logic [15:0] shifted;
  logic [4:0]  edges_inc;

  word_stream_if #(.WIDTH(`RESULT_BITS)) res_if ();

  // chip select and serial clock idle high, so the synchroniser starts there
  pin_sync #(
    .WIDTH (3),
    .INIT  (3'h6)
  ) u_pin_sync (
    .sys_clk_in (sys_clk_in),
    .resetn_in  (resetn_in),
    .pin_in     ({cs_n_in, sclk_in, din_in}),
    .sync_out   (pins_s)
  );

  assign cs_n_s = pins_s[2];
  assign sclk_s = pins_s[1];
  assign din_s  = pins_s[0];

  // the converter core can stall when no transfer drains its results
  result_fifo #(
    .WIDTH (`RESULT_BITS),
    .DEPTH (`FIFO_DEPTH)
  ) u_result_fifo (
    .sys_clk_in   (sys_clk_in),
    .resetn_in    (resetn_in),
    .wr_data_in   (conv_data_in),
    .wr_valid_in  (conv_valid_in),
    .wr_ready_out (conv_ready_out),
    .rd_if        (res_if)
  );

  // narrow variants zero the low bits; twos complement flips the msb
  function automatic logic [11:0] format_result(input logic [11:0] raw,
                                                input logic        straight);
    logic [11:0] val;
    val = raw & (12'hfff << (12 - `RESULT_BITS));
    if (!straight) begin
      val[11] = ~val[11];
    end
    return val;
  endfunction

  function automatic chan_t next_chan(input chan_t cur, input chan_t last);
    return (cur == last) ? 2'h0 : chan_t'(cur + 1'b1);
  endfunction

  assign cs_fall     = r_reg.cs_prev && !cs_n_s;
  assign cs_rise     = !r_reg.cs_prev && cs_n_s;
  assign sclk_fall   = r_reg.sclk_prev && !sclk_s;
  assign sclk_rise   = !r_reg.sclk_prev && sclk_s;
  assign wr_flag     = r_reg.din_sh[`CW_WRITE];
  assign seq_field   = {r_reg.din_sh[`CW_SEQ_HI], r_reg.din_sh[`CW_SEQ_LO]};
  assign edges_inc   = r_reg.edges + 5'h01;
  assign shifted     = {r_reg.dout_sh[14:0], 1'b0};
  assign load_result = (r_reg.st == ST_CONV) && !cs_rise && sclk_fall &&
                       (edges_inc == `RESULT_LOAD_EDGE);
  assign frame_done  = (r_reg.st == ST_TRACK) && !cs_rise && sclk_fall &&
                       (edges_inc == `FRAME_EDGES);
  assign res_if.ready = load_result;

  always_comb begin
    r_next           = r_reg;
    r_next.sclk_prev = sclk_s;
    r_next.cs_prev   = cs_n_s;
    case (r_reg.st)
      ST_IDLE: begin
        if (cs_fall) begin
          r_next.st       = ST_CONV;
          r_next.edges    = 5'h00;
          r_next.hold     = 1'b1;
          r_next.dout_oe  = 1'b1;
          r_next.conv_ch  = r_reg.mux_sel;
          r_next.conv_seq = r_reg.seq_on;
          r_next.dout_sh  = {2'h0, r_reg.mux_sel, 12'h000};
          r_next.din_sh   = 12'h000;
          r_next.asleep   = 1'b0;
        end
      end
      ST_CONV, ST_TRACK: begin
        if (cs_rise) begin
          // early rise: no commit, no sequence step
          r_next.st      = ST_IDLE;
          r_next.hold    = 1'b0;
          r_next.dout_oe = 1'b0;
        end else begin
          // rises 1..12 follow falls 1..12, so the count is already bumped
          if (sclk_rise && (r_reg.edges != 5'h00) &&
              (r_reg.edges <= `CTL_BITS)) begin
            r_next.din_sh = {r_reg.din_sh[10:0], din_s};
          end
          if (sclk_fall) begin
            r_next.edges   = edges_inc;
            r_next.dout_sh = shifted;
            if (load_result) begin
              r_next.dout_sh[14:3] = res_if.valid ?
                format_result(res_if.data, r_reg.ctl.coding) : 12'h000;
            end
            if (edges_inc == `TRACK_EDGE) begin
              r_next.hold = 1'b0;
              r_next.st   = ST_TRACK;
            end
            if (frame_done) begin
              r_next.dout_oe = 1'b0;
              r_next.st      = ST_DONE;
            end
          end
        end
      end
      ST_DONE: begin
        // chip select may idle low here until the host raises it
        if (cs_rise) begin
          r_next.st = ST_IDLE;
        end
      end
      default: begin
        r_next.st = ST_IDLE;
      end
    endcase

    if (frame_done) begin
      if (r_reg.conv_seq && r_reg.seq_on) begin
        r_next.seq_ch = next_chan(r_reg.seq_ch, r_reg.seq_last);
      end
      if (wr_flag) begin
        r_next.ctl.range_sel = r_reg.din_sh[`CW_RANGE];
        r_next.ctl.coding    = r_reg.din_sh[`CW_CODING];
        // the forbidden power code is ignored, old mode stays
        if ({r_reg.din_sh[`CW_PM_HI], r_reg.din_sh[`CW_PM_LO]}
            != `PM_INVALID) begin
          r_next.ctl.pmode = {r_reg.din_sh[`CW_PM_HI],
                              r_reg.din_sh[`CW_PM_LO]};
        end
        if (!(seq_field == `SEQ_KEEP && r_reg.seq_on)) begin
          r_next.ctl.chan = {r_reg.din_sh[`CW_CH_HI],
                             r_reg.din_sh[`CW_CH_LO]};
        end
        if (seq_field == `SEQ_START) begin
          r_next.seq_on   = 1'b1;
          r_next.seq_ch   = 2'h0;
          r_next.seq_last = {r_reg.din_sh[`CW_CH_HI],
                             r_reg.din_sh[`CW_CH_LO]};
        end else if (seq_field != `SEQ_KEEP) begin
          r_next.seq_on = 1'b0;
        end
      end
      if (r_next.ctl.pmode == `PM_AUTO) begin
        r_next.asleep = 1'b1;
      end
    end

    r_next.mux_sel = r_next.seq_on ? r_next.seq_ch : r_next.ctl.chan;
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      r_reg           <= '0;
      r_reg.st        <= ST_IDLE;
      r_reg.cs_prev   <= 1'b1;
      r_reg.sclk_prev <= 1'b1;
      r_reg.ctl.chan  <= `RST_CHAN;
      r_reg.ctl.pmode <= `RST_PMODE;
      r_reg.ctl.range_sel <= `RST_RANGE;
      r_reg.ctl.coding    <= `RST_CODING;
      r_reg.mux_sel   <= `RST_CHAN;
    end else begin
      r_reg <= r_next;
    end
  end

  assign dout_out            = r_reg.dout_sh[15] & r_reg.dout_oe;
  assign dout_oe_out         = r_reg.dout_oe;
  assign mux_sel_out         = r_reg.mux_sel;
  assign hold_out            = r_reg.hold;
  assign range_sel_out       = r_reg.ctl.range_sel;
  assign coding_straight_out = r_reg.ctl.coding;
  assign power_mode_out      = r_reg.ctl.pmode;
  assign shutdown_out        = (r_reg.ctl.pmode == `PM_FULL) || r_reg.asleep;
  assign seq_active_out      = r_reg.seq_on;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);

  sequence frame_start;
    (r_reg.st == ST_IDLE) && cs_fall;
  endsequence

  sequence write_commit;
    frame_done && wr_flag;
  endsequence

  hold_on_fall_a: assert property (
    frame_start |=> hold_out && dout_oe_out && (r_reg.edges == 5'h00))
    else $error("hold or output not started on chip-select fall");

  word_head_a: assert property (
    frame_start |=> (r_reg.dout_sh[15:12] == {2'h0, $past(mux_sel_out)}))
    else $error("result word head is not zeros and channel");

  track_at_fourteen_a: assert property (
    ((r_reg.st == ST_CONV) && !cs_rise && sclk_fall &&
     (r_reg.edges == 5'h0d)) |=> !hold_out ##1 !hold_out)
    else $error("track not resumed on fourteenth falling edge");

  release_at_sixteen_a: assert property (
    frame_done |=> !dout_oe_out && (r_reg.st == ST_DONE))
    else $error("output not released on sixteenth falling edge");

  abort_frame_a: assert property (
    (((r_reg.st == ST_CONV) || (r_reg.st == ST_TRACK)) && cs_rise)
    |=> !dout_oe_out && !hold_out && $stable(r_reg.ctl) &&
        $stable(r_reg.seq_ch))
    else $error("aborted frame changed state or kept output");

  no_write_keeps_a: assert property (
    (frame_done && !wr_flag) |=> $stable(r_reg.ctl))
    else $error("control changed without write flag");

  seq_start_a: assert property (
    (write_commit and (seq_field == `SEQ_START))
    |=> seq_active_out && (mux_sel_out == 2'h0) &&
        (r_reg.seq_last == $past(r_reg.din_sh[`CW_CH_HI:`CW_CH_LO])))
    else $error("sequence not started at channel zero");

  seq_keep_a: assert property (
    (write_commit and (seq_field == `SEQ_KEEP) and r_reg.seq_on)
    |=> seq_active_out && $stable(r_reg.seq_last))
    else $error("keep-sequence write disturbed the sequence");

  seq_end_a: assert property (
    (write_commit and !seq_field[1]) |=> !seq_active_out ##1 !seq_active_out)
    else $error("sequence not ended by write");

  seq_wrap_a: assert property (
    (frame_done && !wr_flag && r_reg.conv_seq && r_reg.seq_on &&
     (r_reg.seq_ch == r_reg.seq_last)) |=> (mux_sel_out == 2'h0))
    else $error("sequence did not wrap to channel zero");

  result_pop_a: assert property (
    (load_result && res_if.valid) |=> (r_reg.edges == `RESULT_LOAD_EDGE))
    else $error("result taken at wrong edge");
endmodule

// file: rtl/sar_seq_defs.svh
`ifndef SAR_SEQ_DEFS_SVH
`define SAR_SEQ_DEFS_SVH

// serial frame
`define FRAME_EDGES      5'h10
`define TRACK_EDGE       5'h0e
`define RESULT_LOAD_EDGE 5'h03
`define CTL_BITS         5'h0c
`define RESULT_BITS      12
`define FIFO_DEPTH       32

// control word bit positions, first bit shifted in lands in bit 11
`define CW_WRITE    11
`define CW_SEQ_HI   10
`define CW_CH_HI    9
`define CW_CH_LO    8
`define CW_PM_HI    7
`define CW_PM_LO    6
`define CW_SEQ_LO   5
`define CW_RANGE    1
`define CW_CODING   0

// field encodings
`define PM_NORMAL   2'h3
`define PM_FULL     2'h2
`define PM_AUTO     2'h1
`define PM_INVALID  2'h0
`define SEQ_START   2'h3
`define SEQ_KEEP    2'h2

// reset values
`define RST_CHAN    2'h0
`define RST_PMODE   2'h3
`define RST_RANGE   1'h0
`define RST_CODING  1'h1

`endif

// file: rtl/sar_seq_pkg.sv
package sar_seq_pkg;
  typedef logic [1:0] chan_t;
  typedef logic [1:0] pmode_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_CONV  = 2'h1,
    ST_TRACK = 2'h3,
    ST_DONE  = 2'h2
  } frame_state_e;

  typedef struct packed {
    chan_t  chan;
    pmode_t pmode;
    logic   range_sel;
    logic   coding;
  } ctl_s;

  typedef struct packed {
    frame_state_e st;
    logic [4:0]   edges;
    logic [11:0]  din_sh;
    logic [15:0]  dout_sh;
    logic         dout_oe;
    logic         hold;
    logic         sclk_prev;
    logic         cs_prev;
    ctl_s         ctl;
    logic         seq_on;
    chan_t        seq_ch;
    chan_t        seq_last;
    chan_t        conv_ch;
    logic         conv_seq;
    chan_t        mux_sel;
    logic         asleep;
  } seq_state_s;
endpackage

// file: rtl/word_stream_if.sv
`timescale 1ns/1ps
interface word_stream_if #(parameter int WIDTH = 12) ();
  logic [WIDTH-1:0] data;
  logic             valid;
  logic             ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

// file: tb/host_port.sv
`timescale 1ns/1ps
module host_port (
  output logic      cs_n_out,
  output logic      sclk_out,
  output logic      din_out,
  input  wire logic dout_in,
  input  wire logic dout_oe_in,
  input  wire logic hold_in
);
  logic [15:0] word;
  logic        hold14;
  logic        hold15;
  logic        oe16;

  // serial clock stands high outside frames
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b1;
    din_out  = 1'b0;
  end

  task automatic xfer(input logic [11:0] cw, input int n);
    // odd offset keeps the link out of phase with the system clock
    #37;
    cs_n_out = 1'b0;
    din_out  = cw[11];
    #800;
    for (int i = 1; i <= n; i++) begin
      word[16-i] = dout_in;
      if (i == 14) hold14 = hold_in;
      if (i == 15) hold15 = hold_in;
      if (i == 16) oe16 = dout_oe_in;
      sclk_out = 1'b0;
      // control bits only on the first 12 rises, held low afterwards
      din_out  = (i <= 12) ? cw[12-i] : 1'b0;
      #400;
      sclk_out = 1'b1;
      #400;
    end
    cs_n_out = 1'b1;
    #1600;
  endtask
endmodule

// file: tb/sar_adc_serial_sequencer_tb.sv
`timescale 1ns/1ps
module sar_adc_serial_sequencer_tb;
  import sar_seq_pkg::*;
  logic        sys_clk_in;
  logic        resetn_in;
  logic        cs_n;
  logic        sclk;
  logic        din;
  logic        dout_out;
  logic        dout_oe_out;
  logic [11:0] conv_data_in;
  logic        conv_valid_in;
  logic        conv_ready_out;
  chan_t       mux_sel_out;
  logic        hold_out;
  logic        range_sel_out;
  logic        coding_straight_out;
  pmode_t      power_mode_out;
  logic        shutdown_out;
  logic        seq_active_out;
  int          err_total;
  int          checks_done;
  logic        tc;

  sar_adc_serial_sequencer i_sar_adc_serial_sequencer (
    .sys_clk_in          (sys_clk_in),
    .resetn_in           (resetn_in),
    .cs_n_in             (cs_n),
    .sclk_in             (sclk),
    .din_in              (din),
    .dout_out            (dout_out),
    .dout_oe_out         (dout_oe_out),
    .conv_data_in        (conv_data_in),
    .conv_valid_in       (conv_valid_in),
    .conv_ready_out      (conv_ready_out),
    .mux_sel_out         (mux_sel_out),
    .hold_out            (hold_out),
    .range_sel_out       (range_sel_out),
    .coding_straight_out (coding_straight_out),
    .power_mode_out      (power_mode_out),
    .shutdown_out        (shutdown_out),
    .seq_active_out      (seq_active_out)
  );

  host_port i_host_port (
    .cs_n_out   (cs_n),
    .sclk_out   (sclk),
    .din_out    (din),
    .dout_in    (dout_out),
    .dout_oe_in (dout_oe_out),
    .hold_in    (hold_out)
  );

  initial sys_clk_in = 1'b0;
  always #50 sys_clk_in = ~sys_clk_in;

  task automatic end_sim;
    if (err_total == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input bit ok, input string msg);
    checks_done++;
    if (!ok) begin
      err_total++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask

  task automatic push(input logic [11:0] raw);
    @(posedge sys_clk_in);
    conv_data_in  <= raw;
    conv_valid_in <= 1'b1;
    @(posedge sys_clk_in);
    conv_valid_in <= 1'b0;
  endtask

  // coding of a result follows the settings before the frame's own write
  task automatic frame(input logic [11:0] cw, input int n,
                       input logic [11:0] raw, input chan_t ch, input bit p);
    logic [11:0] exp;
    exp = tc ? (raw ^ 12'h800) : raw;
    if (p) push(raw);
    i_host_port.xfer(cw, n);
    chk(dout_oe_out === 1'b0 && hold_out === 1'b0, "line not released");
    if (n == 16) begin
      chk(i_host_port.word === {2'h0, ch, exp}, "result word");
      chk(i_host_port.hold14 === 1'b1, "hold early");
      chk(i_host_port.hold15 === 1'b0, "track late");
      chk(i_host_port.oe16 === 1'b1, "output early off");
      if (cw[11]) tc = ~cw[0];
    end
  endtask

  task automatic t_reset;
    chk(mux_sel_out === 2'h0 && range_sel_out === 1'b0, "reset chan");
    chk(coding_straight_out === 1'b1 && conv_ready_out === 1'b1, "reset");
    chk(power_mode_out === 2'h3 && shutdown_out === 1'b0, "reset pm");
    chk(seq_active_out === 1'b0 && dout_oe_out === 1'b0, "reset seq");
  endtask

  task automatic t_plain;
    frame(12'hac2, 16, 12'h5a3, 2'h0, 1'b1);
    chk(mux_sel_out === 2'h2, "mux select");
    chk(range_sel_out === 1'b1 && coding_straight_out === 1'b0, "range");
    frame(12'h380, 16, 12'h123, 2'h2, 1'b1);
    chk(mux_sel_out === 2'h2 && power_mode_out === 2'h3, "no write");
  endtask

  task automatic t_seq;
    frame(12'hee0, 16, 12'h0a5, 2'h2, 1'b1);
    chk(seq_active_out === 1'b1, "seq start");
    for (int k = 0; k < 4; k++) begin
      frame(12'h000, 16, 12'(k + 7), 2'(k % 3), 1'b1);
    end
    frame(12'hcc3, 16, 12'hfff, 2'h1, 1'b1);
    chk(seq_active_out === 1'b1 && range_sel_out === 1'b1, "seq keep");
    frame(12'h000, 16, 12'h800, 2'h2, 1'b1);
    frame(12'hbc1, 16, 12'h7ff, 2'h0, 1'b1);
    chk(seq_active_out === 1'b0, "seq end");
    frame(12'h000, 16, 12'h001, 2'h3, 1'b1);
  endtask

  task automatic t_abort;
    frame(12'h8c3, 10, 12'h444, 2'h0, 1'b1);
    chk(mux_sel_out === 2'h3 && range_sel_out === 1'b0, "abort wrote");
    frame(12'h000, 16, 12'h321, 2'h3, 1'b1);
  endtask

  task automatic t_power;
    frame(12'hb81, 16, 12'h010, 2'h3, 1'b1);
    chk(power_mode_out === 2'h2 && shutdown_out === 1'b1, "full off");
    frame(12'hb01, 16, 12'h020, 2'h3, 1'b1);
    chk(power_mode_out === 2'h2, "invalid mode taken");
    frame(12'hb41, 16, 12'h030, 2'h3, 1'b1);
    chk(power_mode_out === 2'h1 && shutdown_out === 1'b1, "auto off");
    frame(12'hbc1, 16, 12'h040, 2'h3, 1'b1);
    chk(power_mode_out === 2'h3 && shutdown_out === 1'b0, "normal");
  endtask

  // buffer fills with no frames, then frames drain it to empty
  task automatic t_fifo;
    @(posedge sys_clk_in);
    for (int i = 0; i < 32; i++) begin
      conv_data_in  <= 12'(i * 3);
      conv_valid_in <= 1'b1;
      @(posedge sys_clk_in);
    end
    conv_valid_in <= 1'b0;
    @(negedge sys_clk_in);
    chk(conv_ready_out === 1'b0, "buffer not full");
    for (int k = 0; k < 32; k++) begin
      frame(12'h000, 16, 12'(k * 3), 2'h3, 1'b0);
    end
    chk(conv_ready_out === 1'b1, "buffer not drained");
    frame(12'h000, 16, 12'h000, 2'h3, 1'b0);
  endtask

  initial begin
    #5_000_000;
    err_total++;
    end_sim();
  end

  initial begin
    err_total     = 0;
    checks_done   = 0;
    tc            = 1'b0;
    resetn_in     = 1'b0;
    conv_data_in  = 12'h000;
    conv_valid_in = 1'b0;
    repeat (6) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    t_reset();
    t_plain();
    t_seq();
    t_abort();
    t_power();
    t_fifo();
    end_sim();
  end
endmodule
